// File: rtl/rci_pkg.sv
// Purpose: shared constants and types of the reset cause and interrupt block
// Assumes: 8-bit register contents in the low byte of 32-bit bus words
// Notes: offsets are byte addresses on the register bus
package rci_pkg;
   // ==========================================================
   // register map
   localparam int AXI_AW = 8;
   localparam logic [7:0] RC_OFF = 8'h00;
   localparam logic [7:0] EN_OFF = 8'h04;
   localparam logic [7:0] FLG_OFF = 8'h08;
   localparam logic [7:0] STAT_OFF = 8'h0c;
   localparam logic [2:0] SEL_RC = 3'h0;
   localparam logic [2:0] SEL_EN = 3'h1;
   localparam logic [2:0] SEL_FLG = 3'h2;
   localparam logic [2:0] SEL_STAT = 3'h3;
   localparam logic [2:0] SEL_NONE = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // reset cause field positions
   localparam int RC_POR_BIT = 7;
   localparam int RC_EXT_BIT = 6;
   localparam int RC_WDOG_BIT = 5;
   localparam int RC_BADOP_BIT = 4;
   localparam int RC_BADFA_BIT = 3;
   localparam int RC_LOWV_BIT = 1;
   localparam logic [7:0] RC_RESET_VAL = 8'h80;
   // ==========================================================
   // peripheral flag / enable positions
   localparam int SRC_LOCK = 0;
   localparam int SRC_WRAP = 1;
   localparam int SRC_CH0 = 2;
   localparam int SRC_CH1 = 3;
   localparam logic [3:0] EN_RESET_VAL = 4'h0;
   localparam logic [3:0] FLG_RESET_VAL = 4'h0;
   // ==========================================================
   // priorities (0 highest) and vectors
   localparam logic [2:0] PRI_SWI = 3'h0;
   localparam logic [2:0] PRI_EXT = 3'h1;
   localparam logic [2:0] PRI_LOCK = 3'h2;
   localparam logic [2:0] PRI_CH0 = 3'h3;
   localparam logic [2:0] PRI_CH1 = 3'h4;
   localparam logic [2:0] PRI_WRAP = 3'h5;
   localparam logic [15:0] VEC_SWI = 16'hfffc;
   localparam logic [15:0] VEC_EXT = 16'hfffa;
   localparam logic [15:0] VEC_LOCK = 16'hfff8;
   localparam logic [15:0] VEC_CH0 = 16'hfff6;
   localparam logic [15:0] VEC_CH1 = 16'hfff4;
   localparam logic [15:0] VEC_WRAP = 16'hfff2;
   // ==========================================================
   // timing, in oscillator clock cycles (equal to the block clock)
   localparam int RST_DRIVE_CYC = 32;
   localparam int RST_SAMPLE_CYC = 32;
   localparam logic [5:0] DRIVE_LAST = 6'(RST_DRIVE_CYC - 1);
   localparam logic [5:0] SAMPLE_LAST = 6'(RST_SAMPLE_CYC - 1);
   localparam logic [2:0] PUSH_LAST = 3'h4;
   // ==========================================================
   // state types
   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_DRIVE = 2'b01,
      RS_HOLD = 2'b10,
      RS_EXT = 2'b11
   } rci_rs_e;
   typedef enum logic [1:0] {
      IE_IDLE = 2'b00,
      IE_PUSH = 2'b01,
      IE_VEC = 2'b10
   } rci_ie_e;
endpackage : rci_pkg

// File: rtl/rci_top.sv
// Purpose: reset cause flags, reset pin sequencing and interrupt entry
// Assumes: all inputs synchronous to SYS_CLK_IN; RST_IN is power-on reset
// Notes: CPU stalls while ENTRY_BUSY_OUT is high
// What this block does
// - reset cause register is read-only; any read clears all its flags except those set in the same cycle
// - power-up leaves only the power-on flag set in the reset cause register
// - internal reset drives pin low; sample 32 cycles after release, low sets external flag
// - flags from successive resets accumulate until the register is read
// - external reset pin sets external flag until power-on or read
// - watchdog timeout reset sets watchdog flag until power-on or read
// - illegal opcode and illegal fetch address resets set their own flags
// - low supply reset sets its flag until power-on or read
// - interrupt entry only starts after the current instruction completes
// - entry pushes CPU registers; return restores only the mask, from RTI_MASK_IN
// - entry sets the global mask; a latched interrupt is never pre-empted
// - with mask clear, pending requests checked after each instruction, highest first
// - request pending at return is serviced before the next program instruction
// - the index high register is not stacked on entry
// - priority 0 highest; each source has fixed priority and vector
// - global mask gates every source except the software interrupt
// - software interrupt stacks the PC; hardware interrupts stack PC minus one
// - a break point makes the CPU execute a software interrupt
// - low level on the external request pin latches a request
// - each lock change sets lock flag; request only when its enable set
// - timer wrap sets wrap flag; request only when its enable set
// - channel capture or compare sets channel flag; request when enabled
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rci_top (
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   // register bus
   input wire logic [rci_pkg::AXI_AW-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output var logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output var logic S_AXI_WREADY_OUT,
   output var logic [1:0] S_AXI_BRESP_OUT,
   output var logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [rci_pkg::AXI_AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output var logic S_AXI_ARREADY_OUT,
   output var logic [31:0] S_AXI_RDATA_OUT,
   output var logic [1:0] S_AXI_RRESP_OUT,
   output var logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   // reset sources and reset pin
   input wire logic WDOG_RESET_IN,
   input wire logic BAD_OPCODE_IN,
   input wire logic BAD_FETCH_IN,
   input wire logic LOW_SUPPLY_IN,
   input wire logic RSTPIN_IN,
   output var logic RSTPIN_OUT,
   output var logic RSTPIN_OE_OUT,
   output var logic SYS_RESET_OUT,
   // interrupt sources
   input wire logic EXT_REQ_PIN_N_IN,
   input wire logic PLL_LOCKED_IN,
   input wire logic TMR_WRAP_IN,
   input wire logic [1:0] TMR_CH_EVENT_IN,
   input wire logic BREAK_HIT_IN,
   // CPU side
   input wire logic INSTR_DONE_IN,
   input wire logic SWI_IN,
   input wire logic MASK_SET_IN,
   input wire logic MASK_CLR_IN,
   input wire logic RTI_IN,
   input wire logic RTI_MASK_IN,
   input wire logic [15:0] PC_IN,
   input wire logic [15:0] SP_IN,
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] XLO_IN,
   input wire logic [7:0] CCR_IN,
   output var logic FORCE_SWI_OUT,
   output var logic GIM_OUT,
   output var logic ENTRY_BUSY_OUT,
   output var logic STACK_WE_OUT,
   output var logic [15:0] STACK_ADDR_OUT,
   output var logic [7:0] STACK_DATA_OUT,
   output var logic [15:0] SP_OUT,
   output var logic VEC_LOAD_OUT,
   output var logic [15:0] VECTOR_OUT
);
   import rci_pkg::*;

   // ==========================================================
   // decode helpers
   function automatic logic [2:0] reg_sel(input logic [AXI_AW-1:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      if (w == RC_OFF) reg_sel = SEL_RC;
      else if (w == EN_OFF) reg_sel = SEL_EN;
      else if (w == FLG_OFF) reg_sel = SEL_FLG;
      else if (w == STAT_OFF) reg_sel = SEL_STAT;
      else reg_sel = SEL_NONE;
   endfunction : reg_sel

   function automatic logic [15:0] vec_of(input logic [2:0] p);
      case (p)
         PRI_SWI: vec_of = VEC_SWI;
         PRI_EXT: vec_of = VEC_EXT;
         PRI_LOCK: vec_of = VEC_LOCK;
         PRI_CH0: vec_of = VEC_CH0;
         PRI_CH1: vec_of = VEC_CH1;
         default: vec_of = VEC_WRAP;
      endcase
   endfunction : vec_of

   // ==========================================================
   // register bus slave
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic aw_have_ff, w_have_ff;
   logic [AXI_AW-1:0] awaddr_ff;
   logic [7:0] wdata_ff;
   logic wlane_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [7:0] rc_flags_ff;
   logic [3:0] irq_en_ff, flg_ff;
   logic gim_ff, ext_lat_ff, busy_ff;
   logic [2:0] lat_src_ff;
   logic int_rst;
   logic aw_fire, w_fire, wr_go, ar_fire, rc_rd;
   logic [2:0] wsel, rsel;
   logic [31:0] rmux;

   assign aw_fire = awready_ff && S_AXI_AWVALID_IN;
   assign w_fire = wready_ff && S_AXI_WVALID_IN;
   assign ar_fire = arready_ff && S_AXI_ARVALID_IN;
   assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
   assign wsel = reg_sel(awaddr_ff);
   assign rsel = reg_sel(S_AXI_ARADDR_IN);
   assign rc_rd = ar_fire && (rsel == SEL_RC);

   always_comb begin
      rmux = 32'h0000_0000;
      case (rsel)
         SEL_RC: rmux[7:0] = rc_flags_ff;
         SEL_EN: rmux[3:0] = irq_en_ff;
         SEL_FLG: rmux[3:0] = flg_ff;
         SEL_STAT: rmux[6:0] = {lat_src_ff, busy_ff, ext_lat_ff, 1'b0, gim_ff};
         default: rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 8'h00;
         wlane_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         awready_ff <= !awready_ff && S_AXI_AWVALID_IN && !aw_have_ff && !bvalid_ff;
         wready_ff <= !wready_ff && S_AXI_WVALID_IN && !w_have_ff && !bvalid_ff;
         if (aw_fire) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR_IN;
         end
         if (w_fire) begin
            w_have_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA_IN[7:0];
            wlane_ff <= S_AXI_WSTRB_IN[0];
         end
         if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else begin
         arready_ff <= !arready_ff && S_AXI_ARVALID_IN && !rvalid_ff;
         if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rmux;
            rresp_ff <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign S_AXI_AWREADY_OUT = awready_ff;
   assign S_AXI_WREADY_OUT = wready_ff;
   assign S_AXI_BVALID_OUT = bvalid_ff;
   assign S_AXI_BRESP_OUT = bresp_ff;
   assign S_AXI_ARREADY_OUT = arready_ff;
   assign S_AXI_RVALID_OUT = rvalid_ff;
   assign S_AXI_RDATA_OUT = rdata_ff;
   assign S_AXI_RRESP_OUT = rresp_ff;

   // ==========================================================
   // reset pin sequencer
   rci_rs_e rs_st_ff, nxt_rs_st;
   logic [5:0] rs_cnt_ff, nxt_rs_cnt;
   logic oe_ff, sysrst_ff, ext_set, int_trig;

   assign int_trig = WDOG_RESET_IN || BAD_OPCODE_IN || BAD_FETCH_IN || LOW_SUPPLY_IN;

   always_comb begin
      nxt_rs_st = rs_st_ff;
      nxt_rs_cnt = rs_cnt_ff + 6'h01;
      ext_set = 1'b0;
      case (rs_st_ff)
         RS_IDLE: begin
            nxt_rs_cnt = 6'h00;
            if (int_trig) begin
               nxt_rs_st = RS_DRIVE;
            end else if (!RSTPIN_IN) begin
               nxt_rs_st = RS_EXT;
               ext_set = 1'b1;
            end
         end
         RS_DRIVE: begin
            if (int_trig) begin
               nxt_rs_cnt = 6'h00;
            end else if (rs_cnt_ff == DRIVE_LAST) begin
               nxt_rs_st = RS_HOLD;
               nxt_rs_cnt = 6'h00;
            end
         end
         RS_HOLD: begin
            if (int_trig) begin
               nxt_rs_st = RS_DRIVE;
               nxt_rs_cnt = 6'h00;
            end else if (rs_cnt_ff == SAMPLE_LAST) begin
               nxt_rs_st = RS_IDLE;
               ext_set = !RSTPIN_IN;
            end
         end
         RS_EXT: begin
            nxt_rs_cnt = 6'h00;
            if (int_trig) nxt_rs_st = RS_DRIVE;
            else if (RSTPIN_IN) nxt_rs_st = RS_IDLE;
         end
         default: begin
            nxt_rs_st = RS_IDLE;
            nxt_rs_cnt = 6'h00;
         end
      endcase
   end

   // power-on starts the same pin drive as any internal reset
   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         rs_st_ff <= RS_DRIVE;
         rs_cnt_ff <= 6'h00;
         oe_ff <= 1'b1;
         sysrst_ff <= 1'b1;
      end else begin
         rs_st_ff <= nxt_rs_st;
         rs_cnt_ff <= nxt_rs_cnt;
         oe_ff <= (nxt_rs_st == RS_DRIVE);
         sysrst_ff <= (nxt_rs_st != RS_IDLE);
      end
   end

   assign RSTPIN_OE_OUT = oe_ff;
   assign RSTPIN_OUT = 1'b0;
   assign SYS_RESET_OUT = sysrst_ff;
   assign int_rst = RST_IN || sysrst_ff;

   a_pin_drive: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      (rs_st_ff == RS_IDLE && int_trig) |=> RSTPIN_OE_OUT ##31 RSTPIN_OE_OUT)
      else $error("reset pin not driven for full drive time");

   // ==========================================================
   // reset cause flags; only power-on resets them, set beats read-clear
   logic [7:0] rc_set;

   always_comb begin
      rc_set = 8'h00;
      rc_set[RC_EXT_BIT] = ext_set;
      rc_set[RC_WDOG_BIT] = WDOG_RESET_IN;
      rc_set[RC_BADOP_BIT] = BAD_OPCODE_IN;
      rc_set[RC_BADFA_BIT] = BAD_FETCH_IN;
      rc_set[RC_LOWV_BIT] = LOW_SUPPLY_IN;
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) rc_flags_ff <= RC_RESET_VAL;
      else if (rc_rd) rc_flags_ff <= rc_set;
      else rc_flags_ff <= rc_flags_ff | rc_set;
   end

   a_rc_read_clear: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      (rc_rd && rc_set == 8'h00) |=> (rc_flags_ff == 8'h00))
      else $error("reset cause read did not clear flags");

   a_por_value: assert property (@(posedge SYS_CLK_IN)
      RST_IN |=> (rc_flags_ff == RC_RESET_VAL))
      else $error("power-on value of reset cause wrong");

   a_flags_accum: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      (!rc_rd) |=> ((rc_flags_ff & $past(rc_flags_ff)) == $past(rc_flags_ff)))
      else $error("reset cause flag lost without read");

   a_wdog_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      WDOG_RESET_IN |=> rc_flags_ff[RC_WDOG_BIT] && SYS_RESET_OUT)
      else $error("watchdog reset not recorded");

   // ==========================================================
   // interrupt sources and enables
   logic lock_q_ff, swi_pend_ff, force_swi_ff;
   logic [3:0] flg_set, flg_clr;
   logic take;
   logic [2:0] sel;
   rci_ie_e ie_st_ff;

   always_comb begin
      flg_set = 4'h0;
      flg_set[SRC_LOCK] = (lock_q_ff != PLL_LOCKED_IN);
      flg_set[SRC_WRAP] = TMR_WRAP_IN;
      flg_set[SRC_CH0] = TMR_CH_EVENT_IN[0];
      flg_set[SRC_CH1] = TMR_CH_EVENT_IN[1];
      flg_clr = (wr_go && wsel == SEL_FLG && wlane_ff) ? wdata_ff[3:0] : 4'h0;
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         irq_en_ff <= EN_RESET_VAL;
         flg_ff <= FLG_RESET_VAL;
         lock_q_ff <= 1'b0;
      end else begin
         if (wr_go && wsel == SEL_EN && wlane_ff) irq_en_ff <= wdata_ff[3:0];
         flg_ff <= (flg_ff & ~flg_clr) | flg_set;
         lock_q_ff <= PLL_LOCKED_IN;
      end
   end

   // level on the pin latches; entry to its vector is the acknowledge
   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         ext_lat_ff <= 1'b0;
         swi_pend_ff <= 1'b0;
         force_swi_ff <= 1'b0;
      end else begin
         ext_lat_ff <= (ext_lat_ff && !(take && sel == PRI_EXT))
            || !EXT_REQ_PIN_N_IN;
         swi_pend_ff <= (swi_pend_ff && !(take && sel == PRI_SWI)) || SWI_IN;
         force_swi_ff <= BREAK_HIT_IN;
      end
   end

   assign FORCE_SWI_OUT = force_swi_ff;

   // ==========================================================
   // arbitration: index is priority, lowest index wins
   logic [5:0] req;
   logic sel_v;

   assign req[PRI_SWI] = swi_pend_ff;
   assign req[PRI_EXT] = ext_lat_ff && !gim_ff;
   assign req[PRI_LOCK] = flg_ff[SRC_LOCK] && irq_en_ff[SRC_LOCK] && !gim_ff;
   assign req[PRI_CH0] = flg_ff[SRC_CH0] && irq_en_ff[SRC_CH0] && !gim_ff;
   assign req[PRI_CH1] = flg_ff[SRC_CH1] && irq_en_ff[SRC_CH1] && !gim_ff;
   assign req[PRI_WRAP] = flg_ff[SRC_WRAP] && irq_en_ff[SRC_WRAP] && !gim_ff;

   always_comb begin
      sel = PRI_WRAP;
      sel_v = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         if (req[i]) begin
            sel = 3'(i);
            sel_v = 1'b1;
         end
      end
   end

   // only sampled at an instruction boundary, and never while busy
   assign take = (ie_st_ff == IE_IDLE) && INSTR_DONE_IN && sel_v;

   // ==========================================================
   // entry sequencer
   logic [2:0] push_cnt_ff;
   logic [15:0] pc_sv_ff, sp_ff, vec_ff;
   logic [7:0] a_sv_ff, x_sv_ff, ccr_sv_ff, push_byte;
   logic we_ff, vload_ff;
   logic [15:0] saddr_ff, sp_out_ff;
   logic [7:0] sdata_ff;

   // high index byte is deliberately absent from the frame
   always_comb begin
      case (push_cnt_ff)
         3'h0: push_byte = pc_sv_ff[7:0];
         3'h1: push_byte = pc_sv_ff[15:8];
         3'h2: push_byte = x_sv_ff;
         3'h3: push_byte = a_sv_ff;
         default: push_byte = ccr_sv_ff;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         ie_st_ff <= IE_IDLE;
         push_cnt_ff <= 3'h0;
         lat_src_ff <= PRI_SWI;
         pc_sv_ff <= 16'h0000;
         sp_ff <= 16'h0000;
         a_sv_ff <= 8'h00;
         x_sv_ff <= 8'h00;
         ccr_sv_ff <= 8'h00;
         vec_ff <= 16'h0000;
         busy_ff <= 1'b0;
      end else begin
         case (ie_st_ff)
            IE_IDLE: begin
               if (take) begin
                  ie_st_ff <= IE_PUSH;
                  push_cnt_ff <= 3'h0;
                  lat_src_ff <= sel;
                  vec_ff <= vec_of(sel);
                  pc_sv_ff <= (sel == PRI_SWI) ? PC_IN : PC_IN - 16'h0001;
                  sp_ff <= SP_IN;
                  a_sv_ff <= ACC_IN;
                  x_sv_ff <= XLO_IN;
                  ccr_sv_ff <= CCR_IN;
                  busy_ff <= 1'b1;
               end
            end
            IE_PUSH: begin
               sp_ff <= sp_ff - 16'h0001;
               push_cnt_ff <= push_cnt_ff + 3'h1;
               if (push_cnt_ff == PUSH_LAST) ie_st_ff <= IE_VEC;
            end
            IE_VEC: begin
               ie_st_ff <= IE_IDLE;
               busy_ff <= 1'b0;
            end
            default: ie_st_ff <= IE_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) begin
         we_ff <= 1'b0;
         saddr_ff <= 16'h0000;
         sdata_ff <= 8'h00;
         sp_out_ff <= 16'h0000;
         vload_ff <= 1'b0;
      end else begin
         we_ff <= (ie_st_ff == IE_PUSH);
         saddr_ff <= sp_ff;
         sdata_ff <= push_byte;
         vload_ff <= (ie_st_ff == IE_VEC);
         if (ie_st_ff == IE_VEC) sp_out_ff <= sp_ff;
      end
   end

   // mask: reset sets it, entry sets it, return restores the stacked copy
   always_ff @(posedge SYS_CLK_IN) begin
      if (int_rst) gim_ff <= 1'b1;
      else if (take) gim_ff <= 1'b1;
      else if (RTI_IN) gim_ff <= RTI_MASK_IN;
      else if (MASK_SET_IN) gim_ff <= 1'b1;
      else if (MASK_CLR_IN) gim_ff <= 1'b0;
   end

   assign GIM_OUT = gim_ff;
   assign ENTRY_BUSY_OUT = busy_ff;
   assign STACK_WE_OUT = we_ff;
   assign STACK_ADDR_OUT = saddr_ff;
   assign STACK_DATA_OUT = sdata_ff;
   assign SP_OUT = sp_out_ff;
   assign VEC_LOAD_OUT = vload_ff;
   assign VECTOR_OUT = vec_ff;

   a_no_abort: assert property (@(posedge SYS_CLK_IN) disable iff (int_rst)
      (ie_st_ff == IE_IDLE && !INSTR_DONE_IN) |=> !ENTRY_BUSY_OUT)
      else $error("entry started without instruction boundary");

   a_mask_set: assert property (@(posedge SYS_CLK_IN) disable iff (int_rst)
      take |=> GIM_OUT && ENTRY_BUSY_OUT ##6 VEC_LOAD_OUT && $stable(lat_src_ff))
      else $error("entry did not mask or was pre-empted");

   a_swi_nomask: assert property (@(posedge SYS_CLK_IN) disable iff (int_rst)
      (ie_st_ff == IE_IDLE && INSTR_DONE_IN && swi_pend_ff && gim_ff)
      |=> ENTRY_BUSY_OUT ##6 (VECTOR_OUT == VEC_SWI))
      else $error("software interrupt blocked by mask");

   a_hw_pc: assert property (@(posedge SYS_CLK_IN) disable iff (int_rst)
      (take && sel != PRI_SWI) |=> ##1 STACK_WE_OUT
      && (STACK_DATA_OUT == 8'($past(PC_IN, 2) - 16'h0001)))
      else $error("hardware entry stacked wrong return address");
endmodule : rci_top
`default_nettype wire

// File: tb/rci_pin_model.sv
// Purpose: reset pin wire with pull-up and an outside pull-down
// Assumes: open-drain pin; a high enable pulls it low
// Notes: nothing else drives the wire
`timescale 1ns/100ps
`default_nettype none
module rci_pin_model (
   input wire logic oe_in,
   input wire logic ext_low_in,
   output var logic pin_out
);
   // the pull-up wins only while nobody pulls the wire low
   always_comb pin_out = !(oe_in || ext_low_in);
endmodule : rci_pin_model
`default_nettype wire

// File: tb/rci_top_bench.sv
// Purpose: bench of the reset cause and interrupt block
// Assumes: outputs sampled on falling edges
// Notes: no random stimulus
`timescale 1ns/100ps
`default_nettype none
module rci_top_bench;
   import rci_pkg::*;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("Error %0t got %h exp %h", $time, a, e); end end
   int fail_count = 0;
   int checks_done = 0;
   logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, done = 0;
   logic software_interrupt_instruction = 0, mclr = 0, return_from_interrupt = 0, brk = 0, lock = 0, ext_n = 1, pull = 0, pin, ok, ta, tw;
   logic awr, wrdy, bv, arr, rv, oe, srst, fsw, gim, we, vl, bsy;
   logic [2:0] tev = 0;
   logic [1:0] bresp, rresp, rsp;
   logic [3:0] src = 0;
   logic [7:0] aw = 0, ar = 0, sdat;
   logic [15:0] pc = 0, sp = 0, sadr, vec, spo;
   logic [31:0] wd = 0, rdat, d;
   always #25 clk = ~clk;
   rci_pin_model i_pin (.oe_in(oe), .ext_low_in(pull), .pin_out(pin));
   rci_top i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(aw),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
      .S_AXI_ARADDR_IN(ar), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rr), .WDOG_RESET_IN(src[0]), .BAD_OPCODE_IN(src[1]),
      .BAD_FETCH_IN(src[2]), .LOW_SUPPLY_IN(src[3]), .RSTPIN_IN(pin), .RSTPIN_OUT(),
      .RSTPIN_OE_OUT(oe), .SYS_RESET_OUT(srst), .EXT_REQ_PIN_N_IN(ext_n),
      .PLL_LOCKED_IN(lock), .TMR_WRAP_IN(tev[2]), .TMR_CH_EVENT_IN(tev[1:0]),
      .BREAK_HIT_IN(brk), .INSTR_DONE_IN(done), .SWI_IN(software_interrupt_instruction), .MASK_SET_IN(1'b0),
      .MASK_CLR_IN(mclr), .RTI_IN(return_from_interrupt), .RTI_MASK_IN(1'b0), .PC_IN(pc), .SP_IN(sp),
      .ACC_IN(pc[15:8]), .XLO_IN(sp[15:8]), .CCR_IN(sp[7:0]), .FORCE_SWI_OUT(fsw),
      .GIM_OUT(gim), .ENTRY_BUSY_OUT(bsy), .STACK_WE_OUT(we), .STACK_ADDR_OUT(sadr),
      .STACK_DATA_OUT(sdat), .SP_OUT(spo), .VEC_LOAD_OUT(vl), .VECTOR_OUT(vec));
   task print_verdict;
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task tmo(input logic bad);
      if (bad) begin
         fail_count++;
         $display("Error %0t wait ran out", $time);
         print_verdict;
      end
   endtask : tmo
   task rd(input logic [7:0] a);
      @(posedge clk);
      ar <= a;
      arv <= 1;
      rr <= 1;
      repeat (20) begin @(negedge clk); if (arr === 1'b1) break; end
      @(posedge clk);
      arv <= 0;
      repeat (20) begin @(negedge clk); if (rv === 1'b1) break; end
      ok = rv === 1'b1;
      d = rdat;
      rsp = rresp;
      @(posedge clk);
      rr <= 0;
      tmo(!ok);
   endtask : rd
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      aw <= a;
      wd <= v;
      {awv, wv, br} <= 3'b111;
      repeat (20) begin
         @(negedge clk);
         {ta, tw, ok} = {awr === 1'b1, wrdy === 1'b1, bv === 1'b1};
         if (ok) break;
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end
      rsp = bresp;
      @(posedge clk);
      br <= 0;
      tmo(!ok);
   endtask : wr
   // wait until the system leaves reset
   task settle;
      int n;
      n = 0;
      @(negedge clk);
      while (srst !== 1'b0 && n < 300) begin @(negedge clk); n++; end
      tmo(n >= 300);
   endtask : settle
   task pulse(input logic [4:0] s);
      @(posedge clk);
      {pull, src} <= s;
      @(posedge clk);
      {pull, src} <= 0;
      settle;
   endtask : pulse
   task causes;
      logic [7:0] e [6] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h30, 8'h40};
      for (int i = 0; i < 6; i++) begin
         pulse(i < 4 ? 5'(1 << i) : (i == 4 ? 5'h01 : 5'h10));
         if (i == 4) pulse(5'h02);
         rd(RC_OFF);
         `CHK(d[7:0], e[i])
      end
      $display("reset causes done");
   endtask : causes
   task entry(input int k, input logic [15:0] v, input logic [7:0] lo);
      int n;
      n = 0;
      @(posedge clk);
      pc <= 16'h1234;
      sp <= 16'h00ff;
      {mclr, return_from_interrupt, software_interrupt_instruction, ext_n} <= {k != 0 && k != 6, k == 6, k == 0, k != 1};
      if (k == 2) lock <= !lock;
      if (k == 3) tev <= 3'h7;
      @(posedge clk);
      {mclr, return_from_interrupt, software_interrupt_instruction, ext_n, done, tev} <= 8'h18;
      @(posedge clk);
      done <= 0;
      while (we !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      `CHK(sadr, 16'h00ff)
      `CHK(sdat, lo)
      `CHK(bsy, 1'b1)
      while (vl !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      `CHK(vec, v)
      `CHK(spo, 16'h00fa)
      `CHK(bsy, 1'b0)
      `CHK(gim, 1'b1)
      tmo(n >= 20);
      $display("entry %0d done", k);
   endtask : entry
   // pin held low past the sample point of a watchdog reset
   task pin_sample;
      @(posedge clk);
      {pull, src} <= 5'h11;
      @(posedge clk);
      src <= 4'h0;
      repeat (64) @(posedge clk);
      pull <= 1'b0;
      settle;
      rd(RC_OFF);
      `CHK(d[7:0], 8'h60)
      $display("reset pin sample done");
   endtask : pin_sample
   // a second power-on drops the flag of an earlier reset
   task por_again;
      pulse(5'h08);
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      settle;
      rd(RC_OFF);
      `CHK(d[7:0], 8'h80)
      $display("second power-on done");
   endtask : por_again
   initial begin
      #(50 * 20000);
      tmo(1'b1);
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      settle;
      rd(RC_OFF);
      `CHK(d, 32'h0000_0080)
      rd(RC_OFF);
      `CHK(d, 32'h0000_0000)
      rd(8'h40);
      `CHK(rsp, RESP_SLVERR)
      causes;
      wr(EN_OFF, 32'h0000_000f);
      `CHK(rsp, RESP_OKAY)
      rd(EN_OFF);
      `CHK(d[3:0], 4'hf)
      @(posedge clk);
      brk <= 1;
      @(posedge clk);
      brk <= 0;
      @(negedge clk);
      `CHK(fsw, 1'b1)
      entry(0, VEC_SWI, 8'h34);
      entry(1, VEC_EXT, 8'h33);
      entry(2, VEC_LOCK, 8'h33);
      // flags stay set after entry; each is cleared before the next source is tried
      wr(FLG_OFF, 32'h0000_0001);
      entry(3, VEC_CH0, 8'h33);
      wr(FLG_OFF, 32'h0000_0004);
      entry(4, VEC_CH1, 8'h33);
      wr(FLG_OFF, 32'h0000_0008);
      entry(5, VEC_WRAP, 8'h33);
      entry(6, VEC_WRAP, 8'h33);
      pin_sample;
      por_again;
      print_verdict;
   end
endmodule : rci_top_bench
`default_nettype wire
